// ### rtl/scs_defs.svh
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH

// Conversion time bounds in nanoseconds and derived cycle counts at 40 MHz.
`define SCS_CLK_PERIOD_NS   25
`define SCS_TCONV_MIN_NS    600
`define SCS_TCONV_MAX_NS    670
`define SCS_CONV_MIN_CYC    ((`SCS_TCONV_MIN_NS + `SCS_CLK_PERIOD_NS - 1) / `SCS_CLK_PERIOD_NS)
`define SCS_CONV_MAX_CYC    (`SCS_TCONV_MAX_NS / `SCS_CLK_PERIOD_NS)

// Result codes.
`define SCS_CODE_MOST_NEG   20'h80000
`define SCS_CODE_MOST_POS   20'h7FFFF
`define SCS_CODE_ZERO       20'h00000

// Reset values of trim, range and clock selection.
`define SCS_TRIM_RESET      5'h00
`define SCS_RANGE_RESET     3'h0
`define SCS_CLKSEL_RESET    2'h0

// Transfer clock selection encodings.
`define SCS_CLKSEL_INT      2'h0
`define SCS_CLKSEL_EXT      2'h1
`define SCS_CLKSEL_MIX      2'h2

`endif

// ### rtl/scs_osc_timer.sv
`timescale 1ns/1ps
`include "scs_defs.svh"

// Internal conversion oscillator: counts a pseudo-random length between the
// minimum and maximum conversion time, so conversion length varies per cycle.
module scs_osc_timer #(
  parameter int MIN_CYC = `SCS_CONV_MIN_CYC,
  parameter int MAX_CYC = `SCS_CONV_MAX_CYC
) (
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rstn,
  // Control
  input  wire logic i_start,
  output logic      o_done,
  output logic      o_osc_tick
);

  localparam int SPAN = MAX_CYC - MIN_CYC + 1;

  logic [7:0] count;
  logic [7:0] next_count;
  logic [7:0] lfsr;
  logic [7:0] next_lfsr;
  logic [7:0] target;
  logic [7:0] next_target;
  logic       run;
  logic       next_run;

  always_comb
  begin
    next_lfsr   = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    next_count  = count;
    next_target = target;
    next_run    = run;
    if (i_start)
    begin
      next_run    = 1'b1;
      next_count  = 8'h01;
      next_target = 8'(MIN_CYC) + 8'(32'(lfsr) % SPAN);
    end
    else if (run)
    begin
      if (count >= target)
      begin
        next_run = 1'b0;
      end
      else
      begin
        next_count = count + 8'h01;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      count  <= 8'h00;
      lfsr   <= 8'h5A;
      target <= 8'h00;
      run    <= 1'b0;
    end
    else
    begin
      count  <= next_count;
      lfsr   <= next_lfsr;
      target <= next_target;
      run    <= next_run;
    end
  end

  assign o_done     = run && (count >= target);
  assign o_osc_tick = run;

endmodule

// ### rtl/scs_pkg.sv
package scs_pkg;

  typedef enum logic [0:0] {
    SCS_ACQUIRE = 1'b0,
    SCS_CONVERT = 1'b1
  } scs_state_type;

  typedef enum logic [1:0] {
    SCS_XFER_IDLE = 2'b00,
    SCS_XFER_LOAD = 2'b01,
    SCS_XFER_SHIFT = 2'b10
  } scs_xfer_type;

endpackage

// ### rtl/scs_sar_conversion_sequencer.sv
`timescale 1ns/1ps
`include "scs_defs.svh"

// Functional notes
// - Conversion-start rising edge in acquisition enters conversion, switching charge to reference.
// - Conversion timed by internal oscillator; length varies between min and max.
// - While converting, inputs isolated and sampled values held.
// - At conversion end reconnect inputs and return to acquisition automatically.
// - Core takes reset and start, returns status and result.
// - Results are signed two's-complement codes of the differential input.
// - At or below negative full scale gives 80000; zero 00000; top saturates 7FFFF.
// - Transfers clocked by internal oscillator, host clock, or both, by configuration; internal selection also shifts every i_mclk cycle while acquiring.
// - Interface holds input and output shift registers, configuration and protocol unit.
// - Five-bit reference offset trim adds or subtracts offset at buffer output.
// - Further conversion-start transitions ignored until conversion completes.
// - Conversion status low during conversion, high when it ends.
module scs_sar_conversion_sequencer
  import scs_pkg::*;
#(
  parameter int RES_W  = 20,
  parameter int WORD_W = 22
) (
  // Clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_rstn,
  // Conversion control
  input  wire logic              i_conversion_start,
  output logic                   o_conversion_status,
  output logic                   o_inputs_connected,
  output logic                   o_reference_switched,
  // Analog front end, digitised difference analog_in_positive minus analog_in_negative
  input  wire logic signed [RES_W:0] i_analog_diff,
  output logic [RES_W-1:0]       o_result,
  // Reference buffer control
  input  wire logic [2:0]        i_reference_range,
  input  wire logic [4:0]        i_reference_offset_trim,
  output logic [2:0]             o_reference_range,
  output logic [4:0]             o_reference_offset_trim,
  // Serial transfer
  input  wire logic [1:0]        i_clock_select,
  input  wire logic              i_frame_active,
  input  wire logic              i_host_sclk_edge,
  input  wire logic              i_serial_in,
  output logic                   o_serial_out,
  output logic [WORD_W-1:0]      o_command_word
);

  scs_state_type            state;
  scs_state_type            next_state;
  logic                     start_prev;
  logic                     osc_start;
  logic                     osc_done;
  logic                     osc_tick;
  logic signed [RES_W:0]    held;
  logic signed [RES_W:0]    next_held;
  logic [RES_W-1:0]         result;
  logic [RES_W-1:0]         next_result;
  logic                     status;
  logic                     next_status;

  // Rising edge of conversion-start, only honoured while acquiring.
  assign osc_start = i_conversion_start && !start_prev && (state == SCS_ACQUIRE);

  scs_osc_timer u_osc (
    .i_mclk     (i_mclk),
    .i_rstn     (i_rstn),
    .i_start    (osc_start),
    .o_done     (osc_done),
    .o_osc_tick (osc_tick)
  );

  // Saturating two's-complement coding of the held difference.
  function automatic logic [RES_W-1:0] code_of(input logic signed [RES_W:0] v);
    logic signed [RES_W:0] lo;
    logic signed [RES_W:0] hi;
    lo = -(21'sd1 <<< (RES_W - 1));
    hi = (21'sd1 <<< (RES_W - 1)) - 21'sd1;
    if (v <= lo)
    begin
      code_of = `SCS_CODE_MOST_NEG;
    end
    else if (v >= hi)
    begin
      code_of = `SCS_CODE_MOST_POS;
    end
    else
    begin
      code_of = v[RES_W-1:0];
    end
  endfunction

  always_comb
  begin
    next_state  = state;
    next_held   = held;
    next_result = result;
    next_status = status;
    case (state)
      SCS_ACQUIRE:
      begin
        next_held = i_analog_diff;
        if (osc_start)
        begin
          next_state  = SCS_CONVERT;
          next_status = 1'b0;
        end
      end
      SCS_CONVERT:
      begin
        if (osc_done)
        begin
          next_state  = SCS_ACQUIRE;
          next_result = code_of(held);
          next_status = 1'b1;
        end
      end
      default:
      begin
        next_state = SCS_ACQUIRE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state      <= SCS_ACQUIRE;
      start_prev <= 1'b0;
      held       <= '0;
      result     <= `SCS_CODE_ZERO;
      status     <= 1'b1;
    end
    else
    begin
      state      <= next_state;
      start_prev <= i_conversion_start;
      held       <= next_held;
      result     <= next_result;
      status     <= next_status;
    end
  end

  assign o_conversion_status  = status;
  assign o_result             = result;
  assign o_inputs_connected   = (state == SCS_ACQUIRE);
  assign o_reference_switched = (state == SCS_CONVERT);

  // Configuration registers, captured while no frame runs.
  logic [2:0] cfg_range;
  logic [4:0] cfg_trim;
  logic [1:0] cfg_clksel;

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cfg_range  <= `SCS_RANGE_RESET;
      cfg_trim   <= `SCS_TRIM_RESET;
      cfg_clksel <= `SCS_CLKSEL_RESET;
    end
    else if (!i_frame_active)
    begin
      cfg_range  <= i_reference_range;
      cfg_trim   <= i_reference_offset_trim;
      cfg_clksel <= i_clock_select;
    end
  end

  assign o_reference_range       = cfg_range;
  assign o_reference_offset_trim = cfg_trim;

  // Protocol unit with input and output shift registers.
  scs_xfer_type        xstate;
  scs_xfer_type        next_xstate;
  logic [WORD_W-1:0]   osr;
  logic [WORD_W-1:0]   next_osr;
  logic [WORD_W-1:0]   isr;
  logic [WORD_W-1:0]   next_isr;
  logic [WORD_W-1:0]   cmd;
  logic [WORD_W-1:0]   next_cmd;
  logic                shift_en;

  always_comb
  begin
    case (cfg_clksel)
      `SCS_CLKSEL_INT: shift_en = osc_tick || (state == SCS_ACQUIRE);
      `SCS_CLKSEL_EXT: shift_en = i_host_sclk_edge;
      `SCS_CLKSEL_MIX: shift_en = i_host_sclk_edge || osc_tick;
      default:         shift_en = i_host_sclk_edge;
    endcase
  end

  always_comb
  begin
    next_xstate = xstate;
    next_osr    = osr;
    next_isr    = isr;
    next_cmd    = cmd;
    case (xstate)
      SCS_XFER_IDLE:
      begin
        if (i_frame_active)
        begin
          next_xstate = SCS_XFER_LOAD;
        end
      end
      SCS_XFER_LOAD:
      begin
        next_osr    = {result, 2'b00};
        next_xstate = SCS_XFER_SHIFT;
      end
      SCS_XFER_SHIFT:
      begin
        if (!i_frame_active)
        begin
          next_cmd    = isr;
          next_xstate = SCS_XFER_IDLE;
        end
        else if (shift_en)
        begin
          next_osr = {osr[WORD_W-2:0], 1'b0};
          next_isr = {isr[WORD_W-2:0], i_serial_in};
        end
      end
      default:
      begin
        next_xstate = SCS_XFER_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      xstate <= SCS_XFER_IDLE;
      osr    <= '0;
      isr    <= '0;
      cmd    <= '0;
    end
    else
    begin
      xstate <= next_xstate;
      osr    <= next_osr;
      isr    <= next_isr;
      cmd    <= next_cmd;
    end
  end

  assign o_serial_out   = osr[WORD_W-1];
  assign o_command_word = cmd;

endmodule

// ### verification/scs_checker_properties.sv
`timescale 1ns/1ps
module scs_checker (
  // Clock and reset
  input wire logic               i_mclk,
  input wire logic               i_rstn,
  // Watched ports
  input wire logic               i_conversion_start,
  input wire logic signed [20:0] i_analog_diff,
  input wire logic               o_conversion_status,
  input wire logic               o_inputs_connected,
  input wire logic               o_reference_switched,
  input wire logic [19:0]        o_result
);
  logic [5:0]  low_cnt;
  logic [19:0] held;
  logic        start_q;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  function automatic logic [19:0] sat(logic signed [20:0] d);
    if (d <= -21'sh080000) return 20'h80000;
    if (d >= 21'sh07FFFF) return 20'h7FFFF;
    return d[19:0];
  endfunction
  // Counts low status cycles and keeps the code due for the sample taken at start.
  always_ff @(posedge i_mclk or negedge i_rstn)
    if (!i_rstn)
    begin
      low_cnt <= 6'h00;
      start_q <= 1'b0;
      held    <= 20'h00000;
    end
    else
    begin
      low_cnt <= o_conversion_status ? 6'h00 : low_cnt + 6'h01;
      start_q <= i_conversion_start;
      if (o_conversion_status && i_conversion_start && !start_q)
        held <= sat(i_analog_diff);
    end
  property p_enter;
    o_conversion_status && i_conversion_start && !start_q
      |=> !o_conversion_status && o_reference_switched;
  endproperty
  property p_isolate;
    !o_conversion_status |-> !o_inputs_connected && o_reference_switched;
  endproperty
  property p_status;
    o_conversion_status |-> o_inputs_connected && !o_reference_switched;
  endproperty
  property p_length;
    $rose(o_conversion_status) |-> low_cnt >= 6'h18 && low_cnt <= 6'h1A;
  endproperty
  property p_bound;
    !o_conversion_status |-> low_cnt <= 6'h19;
  endproperty
  property p_code;
    $rose(o_conversion_status) |-> o_result == held;
  endproperty
  property p_ignore;
    $rose(o_conversion_status) && !(i_conversion_start && !start_q) |=> o_conversion_status;
  endproperty
  property p_hold;
    !$rose(o_conversion_status) |-> $stable(o_result);
  endproperty
  a_enter: assert property (p_enter) else $error("start edge not taken");
  a_isolate: assert property (p_isolate) else $error("inputs not isolated");
  a_status: assert property (p_status) else $error("status and state disagree");
  a_length: assert property (p_length) else $error("conversion length off");
  a_bound: assert property (p_bound) else $error("no return to acquire");
  a_code: assert property (p_code) else $error("wrong result code");
  a_ignore: assert property (p_ignore) else $error("conversion restarted");
  a_hold: assert property (p_hold) else $error("result changed early");
  c_conv: cover property ($fell(o_conversion_status));
  c_neg: cover property ($rose(o_conversion_status) && o_result == 20'h80000);
  c_pos: cover property ($rose(o_conversion_status) && o_result == 20'h7FFFF);
endmodule
bind scs_sar_conversion_sequencer scs_checker chk_u (.i_mclk, .i_rstn, .i_conversion_start,
  .i_analog_diff, .o_conversion_status, .o_inputs_connected, .o_reference_switched, .o_result);

// ### verification/scs_host_model.sv
`timescale 1ns/1ps
module scs_host_model #(
  parameter logic [2:0] NEAR_RANGE = 3'h2
) (
  input  wire logic       i_mclk,
  input  wire logic       i_go,
  input  wire logic [5:0] i_hold_len,
  output logic            o_conversion_start,
  output logic [2:0]      o_reference_range
);
  logic [5:0] cnt = 6'h00;
  assign o_reference_range = NEAR_RANGE;
  initial o_conversion_start = 1'b0;
  always @(posedge i_mclk)
    cnt <= i_go ? i_hold_len : (cnt != 6'h00 ? cnt - 6'h01 : cnt);
  // Start moves only on the falling edge, away from the sampling edge.
  always @(negedge i_mclk)
    o_conversion_start <= cnt != 6'h00;
endmodule

// ### verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic               i_mclk = 1'b0;
  logic               i_rstn = 1'b0;
  logic               go = 1'b0;
  logic [5:0]         hold_len = 6'h02;
  logic signed [20:0] diff = 21'h000000;
  logic [4:0]         trim = 5'h00;
  logic               frame = 1'b0;
  logic [1:0]         clksel = 2'h0;
  logic               sclk_edge = 1'b0;
  logic               sin = 1'b0;
  wire logic          start, status, conn, refsw, sout;
  wire logic [21:0]   cmdw;
  wire logic [19:0]   res;
  wire logic [2:0]    rng, rng_o;
  wire logic [4:0]    trim_o;
  int                 errors = 0;
  int                 checks_done = 0;
  int                 cyc = 0;
  int                 n;
  logic [20:0] din [9] = '{21'h17FFFF, 21'h180000, 21'h180001, 21'h1FFFFF, 21'h000000,
                           21'h000001, 21'h07FFFE, 21'h07FFFF, 21'h080000};
  logic [19:0] dexp [9] = '{20'h80000, 20'h80000, 20'h80001, 20'hFFFFF, 20'h00000,
                            20'h00001, 20'h7FFFE, 20'h7FFFF, 20'h7FFFF};
  scs_host_model host_u (.i_mclk(i_mclk), .i_go(go), .i_hold_len(hold_len),
    .o_conversion_start(start), .o_reference_range(rng));
  scs_sar_conversion_sequencer dut_u (.i_mclk(i_mclk), .i_rstn(i_rstn),
    .i_conversion_start(start), .o_conversion_status(status), .o_inputs_connected(conn),
    .o_reference_switched(refsw), .i_analog_diff(diff), .o_result(res),
    .i_reference_range(rng), .i_reference_offset_trim(trim), .o_reference_range(rng_o),
    .o_reference_offset_trim(trim_o), .i_clock_select(clksel), .i_frame_active(frame),
    .i_host_sclk_edge(sclk_edge), .i_serial_in(sin), .o_serial_out(sout),
    .o_command_word(cmdw));
  always #12.5 i_mclk = ~i_mclk;
  task conclude;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      errors++;
      conclude();
    end
  end
  task chk(input string name, input logic [21:0] exp, input logic [21:0] got);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One conversion; the input moves once the sample is held.
  task conv(input logic [20:0] d, input logic [5:0] len, input logic [19:0] e);
    @(negedge i_mclk);
    diff = d;
    hold_len = len;
    go = 1'b1;
    @(negedge i_mclk);
    go = 1'b0;
    n = 0;
    while (status && n < 6)
    begin
      @(negedge i_mclk);
      n++;
    end
    diff = ~d;
    chk("isolated", 20'h00002, {refsw, conn});
    n = 0;
    while (!status && n < 40)
    begin
      @(negedge i_mclk);
      n++;
    end
    chk("length", 1, n >= 24 && n <= 26);
    chk("result", e, res);
    chk("connected", 1, conn);
  endtask
  initial
  begin
    repeat (2) @(negedge i_mclk);
    chk("rst_state", 20'h00005, {status, refsw, conn});
    chk("rst_result", 0, res);
    i_rstn = 1'b1;
    for (int i = 0; i < 9; i++)
      conv(din[i], 6'h02, dexp[i]);
    conv(21'h000123, 6'h28, 20'h00123);
    repeat (3) @(negedge i_mclk);
    chk("no_restart", 1, status);
    repeat (20) @(negedge i_mclk);
    // A short start pulse, so start is low again when reset is released.
    hold_len = 6'h02;
    go = 1'b1;
    @(negedge i_mclk);
    go = 1'b0;
    repeat (6) @(negedge i_mclk);
    i_rstn = 1'b0;
    @(negedge i_mclk);
    chk("mid_rst", 20'h00005, {status, refsw, conn});
    chk("mid_rst_res", 0, res);
    i_rstn = 1'b1;
    conv(21'h1FFFFF, 6'h02, 20'hFFFFF);
    trim = 5'h15;
    repeat (2) @(negedge i_mclk);
    chk("trim", 5'h15, trim_o);
    chk("range", 3'h2, rng_o);
    frame = 1'b1;
    trim = 5'h0A;
    repeat (3) @(negedge i_mclk);
    chk("serial_msb", 1, sout);
    chk("trim_frozen", 5'h15, trim_o);
    frame = 1'b0;
    repeat (2) @(negedge i_mclk);
    // Host clock and mixed selection: no shift without host edges while acquiring.
    sin = 1'b1;
    for (int s = 1; s < 3; s++)
    begin
      clksel = 2'(s);
      @(negedge i_mclk);
      frame = 1'b1;
      repeat (25) @(negedge i_mclk);
      chk("sel_hold", 1, sout);
      sclk_edge = 1'b1;
      repeat (22) @(negedge i_mclk);
      sclk_edge = 1'b0;
      chk("sel_shift", 0, sout);
      frame = 1'b0;
      repeat (2) @(negedge i_mclk);
      chk("command", 22'h3FFFFF, cmdw);
    end
    conclude();
  end
endmodule
